// *** hdl/bavms_pkg.sv ***
// constants and carrier types for bus address and setpoint source selection
// assumes a single 10 MHz clock and synchronous active-high reset
package bavms_pkg;
  localparam int          ADDR_W       = 7;
  localparam logic [6:0]  I2C_BASE_RST = 7'h10;
  localparam logic [6:0]  PM_BASE_RST  = 7'h40;
  localparam int          OFS_W        = 4;
  localparam int          EDGE_N       = 15;
  localparam int          ADC_W        = 10;
  localparam int          RES_W        = 16;
  localparam logic [15:0] OHM_PER_LSB  = 16'h000C;
  // upper band edges in ohms, between the nominal strap values
  localparam logic [EDGE_N-1:0][15:0] BAND_EDGE = {
    16'h2BF2, 16'h27F6, 16'h2463, 16'h20B2, 16'h1D01,
    16'h196E, 16'h1603, 16'h1310, 16'h1054, 16'h0DCF,
    16'h0B6D, 16'h091A, 16'h0703, 16'h050F, 16'h0306};
  localparam int          DATA_W       = 8;
  localparam logic [2:0]  SEL_I2C      = 3'h0;
  localparam logic [2:0]  SEL_PM       = 3'h1;
  localparam logic [2:0]  SEL_CTRL     = 3'h2;
  localparam logic [2:0]  SEL_BOOT     = 3'h3;
  localparam logic [2:0]  SEL_STAT     = 3'h4;
  localparam logic [2:0]  SEL_CODE     = 3'h5;
  localparam int          CTRL_IGN_OFS = 0;
  localparam int          CTRL_VID     = 1;
  localparam int          STAT_INIT    = 4;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  BOOT_RST     = 8'h00;
  localparam int          MV_W         = 12;
  localparam logic [7:0]  VID_MIN      = 8'h1F;
  localparam logic [11:0] VID_MIN_MV   = 12'h190;
  localparam logic [11:0] VID_STEP_MV  = 12'h005;
  localparam int          CLK_NS       = 100;
  localparam int          RAMP_STEP_NS = 1000;
  localparam int          RAMP_CYC     = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          TICK_W       = 8;

  typedef enum logic [2:0] {
    BAVMS_ADC_REQ  = 3'b000,
    BAVMS_ADC_WAIT = 3'b001,
    BAVMS_RUN_PM   = 3'b010,
    BAVMS_VID_BOOT = 3'b011,
    BAVMS_VID_RUN  = 3'b100
  } bavms_state_t;

  typedef struct packed {
    logic             valid;
    logic [ADDR_W-1:0] addr;
  } bavms_addr_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } bavms_vid_cmd_t;

  typedef struct packed {
    bavms_state_t      st;
    logic [OFS_W-1:0]  ofs;
    logic [ADDR_W-1:0] i2c_base;
    logic [ADDR_W-1:0] pm_base;
    logic [7:0]        ctrl;
    logic [7:0]        boot;
    logic [MV_W-1:0]   pm_vout;
    logic [7:0]        cur;
    logic [7:0]        tgt;
    logic [TICK_W-1:0] tick;
    logic              adc_start;
    logic              i2c_ack;
    logic              pm_ack;
    logic              vid_bad;
    logic              reg_en;
    logic [MV_W-1:0]   target;
    logic [7:0]        rdata;
  } bavms_regs_t;
endpackage

// *** hdl/bavms_top.sv ***
// address matching with strap offset and setpoint source selection
// assumes bus front ends deliver decoded address bytes and config writes in clock domain
`timescale 1ns/1ps

// Contract
// - separate 7-bit I2C and PMBus base registers
// - zero I2C base ignores I2C only
// - zero PMBus base ignores PMBus only
// - defaults 0x10 and 0x40, strap adds offset
// - strap sampled once by 10-bit converter
// - rising resistance bands map to offsets 0-15
// - acknowledge base plus offset on enabled bus
// - ignore-offset bit answers at plain base
// - identification mode ramps to boot code
// - after boot, follow each CPU code
// - code zero means 0 V and shutdown
// - mode zero uses PMBus voltage only
// - telemetry reachable on both buses in every mode after strap sample
// - 5 mV table, 1F to FF, low codes invalid
module bavms_top #(
  parameter int RAMP_CYCLES = bavms_pkg::RAMP_CYC
) (
  input  wire logic                        CLOCK,
  input  wire logic                        SRST,
  input  wire bavms_pkg::bavms_addr_req_t  I2C_REQ,
  input  wire bavms_pkg::bavms_addr_req_t  PM_REQ,
  output logic                             I2C_ACK,
  output logic                             PM_ACK,
  output logic                             ADC_START,
  input  wire logic                        ADC_DONE,
  input  wire logic [9:0]                  ADC_DATA,
  input  wire logic                        CFG_WE,
  input  wire logic [2:0]                  CFG_SEL,
  input  wire logic [7:0]                  CFG_WDATA,
  output logic      [7:0]                  CFG_RDATA,
  input  wire logic                        PM_VOUT_WE,
  input  wire logic [11:0]                 PM_VOUT,
  input  wire bavms_pkg::bavms_vid_cmd_t   VID_CMD,
  output logic                             VID_BAD,
  output logic                             REG_EN,
  output logic      [11:0]                 TARGET_MV
);

  bavms_pkg::bavms_regs_t r_r;
  bavms_pkg::bavms_regs_t r_nxt;

  logic [bavms_pkg::RES_W-1:0]  res_ohm;
  logic [bavms_pkg::EDGE_N-1:0] above;
  logic [bavms_pkg::OFS_W-1:0]  band;
  logic [6:0]                   ofs_use;
  logic [6:0]                   i2c_eff;
  logic [6:0]                   pm_eff;
  logic                         init_done;
  logic                         tick;
  logic [11:0]                  cur_mv;

  assign res_ohm = 16'({6'h00, ADC_DATA} * bavms_pkg::OHM_PER_LSB);

  // one comparator per band edge
  genvar gi;
  generate
    for (gi = 0; gi < bavms_pkg::EDGE_N; gi++) begin : g_edge
      assign above[gi] = res_ohm >= bavms_pkg::BAND_EDGE[gi];
    end
  endgenerate

  always_comb begin
    band = 4'h0;
    for (int i = 0; i < bavms_pkg::EDGE_N; i++) begin
      band = band + {3'h0, above[i]};
    end
  end

  assign ofs_use   = r_r.ctrl[bavms_pkg::CTRL_IGN_OFS] ? 7'h00 : {3'h0, r_r.ofs};
  assign i2c_eff   = 7'(r_r.i2c_base + ofs_use);
  assign pm_eff    = 7'(r_r.pm_base + ofs_use);
  assign init_done = (r_r.st != bavms_pkg::BAVMS_ADC_REQ) &&
                     (r_r.st != bavms_pkg::BAVMS_ADC_WAIT);
  assign tick      = (r_r.tick == '0);
  assign cur_mv    = (r_r.cur == 8'h00) ? 12'h000 :
                     12'(bavms_pkg::VID_MIN_MV +
                         ({4'h0, r_r.cur - bavms_pkg::VID_MIN} * bavms_pkg::VID_STEP_MV));

  always_comb begin
    r_nxt           = r_r;
    r_nxt.adc_start = 1'b0;
    r_nxt.vid_bad   = 1'b0;
    r_nxt.tick      = tick ? bavms_pkg::TICK_W'(RAMP_CYCLES - 1) : r_r.tick - 1'b1;

    // addresses answer in every mode, so telemetry stays reachable on both buses
    r_nxt.i2c_ack = init_done && I2C_REQ.valid && (r_r.i2c_base != 7'h00) &&
                    (I2C_REQ.addr == i2c_eff);
    r_nxt.pm_ack  = init_done && PM_REQ.valid && (r_r.pm_base != 7'h00) &&
                    (PM_REQ.addr == pm_eff);

    if (CFG_WE) begin
      case (CFG_SEL)
        bavms_pkg::SEL_I2C:  r_nxt.i2c_base = CFG_WDATA[6:0];
        bavms_pkg::SEL_PM:   r_nxt.pm_base  = CFG_WDATA[6:0];
        bavms_pkg::SEL_CTRL: r_nxt.ctrl     = {6'h00, CFG_WDATA[1:0]};
        bavms_pkg::SEL_BOOT: r_nxt.boot     = CFG_WDATA;
        default: ;
      endcase
    end
    if (PM_VOUT_WE) begin
      r_nxt.pm_vout = PM_VOUT;
    end

    case (CFG_SEL)
      bavms_pkg::SEL_I2C:  r_nxt.rdata = {1'b0, r_r.i2c_base};
      bavms_pkg::SEL_PM:   r_nxt.rdata = {1'b0, r_r.pm_base};
      bavms_pkg::SEL_CTRL: r_nxt.rdata = r_r.ctrl;
      bavms_pkg::SEL_BOOT: r_nxt.rdata = r_r.boot;
      bavms_pkg::SEL_STAT: r_nxt.rdata = {3'h0, init_done, r_r.ofs};
      bavms_pkg::SEL_CODE: r_nxt.rdata = r_r.cur;
      default:             r_nxt.rdata = 8'h00;
    endcase

    // ramp one code per tick toward the target, skipping the invalid low codes
    if (tick && (r_r.cur != r_r.tgt) && (r_r.tgt != 8'h00)) begin
      if (r_r.cur < bavms_pkg::VID_MIN) begin
        r_nxt.cur = bavms_pkg::VID_MIN;
      end else if (r_r.cur < r_r.tgt) begin
        r_nxt.cur = r_r.cur + 8'h01;
      end else begin
        r_nxt.cur = r_r.cur - 8'h01;
      end
    end

    case (r_r.st)
      bavms_pkg::BAVMS_ADC_REQ: begin
        r_nxt.adc_start = 1'b1;
        r_nxt.st        = bavms_pkg::BAVMS_ADC_WAIT;
      end
      bavms_pkg::BAVMS_ADC_WAIT: begin
        if (ADC_DONE) begin
          r_nxt.ofs = band;
          r_nxt.st  = bavms_pkg::BAVMS_RUN_PM;
        end
      end
      bavms_pkg::BAVMS_RUN_PM: begin
        r_nxt.target = r_r.pm_vout;
        r_nxt.reg_en = 1'b1;
        if (r_r.ctrl[bavms_pkg::CTRL_VID]) begin
          r_nxt.st  = bavms_pkg::BAVMS_VID_BOOT;
          r_nxt.cur = 8'h00;
          r_nxt.tgt = r_r.boot;
        end
      end
      bavms_pkg::BAVMS_VID_BOOT: begin
        r_nxt.target = cur_mv;
        r_nxt.reg_en = (r_r.tgt != 8'h00);
        if (!r_r.ctrl[bavms_pkg::CTRL_VID]) begin
          r_nxt.st = bavms_pkg::BAVMS_RUN_PM;
        end else if ((r_r.cur == r_r.tgt) || (r_r.tgt == 8'h00)) begin
          r_nxt.st = bavms_pkg::BAVMS_VID_RUN;
        end
      end
      bavms_pkg::BAVMS_VID_RUN: begin
        r_nxt.target = cur_mv;
        r_nxt.reg_en = (r_r.tgt != 8'h00);
        if (!r_r.ctrl[bavms_pkg::CTRL_VID]) begin
          r_nxt.st = bavms_pkg::BAVMS_RUN_PM;
        end else if (VID_CMD.valid) begin
          if (VID_CMD.code == 8'h00) begin
            r_nxt.tgt    = 8'h00;
            r_nxt.cur    = 8'h00;
            r_nxt.reg_en = 1'b0;
          end else if (VID_CMD.code < bavms_pkg::VID_MIN) begin
            r_nxt.vid_bad = 1'b1;
          end else begin
            r_nxt.tgt = VID_CMD.code;
          end
        end
      end
      default: r_nxt.st = bavms_pkg::BAVMS_ADC_REQ;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      r_r          <= '0;
      r_r.st       <= bavms_pkg::BAVMS_ADC_REQ;
      r_r.i2c_base <= bavms_pkg::I2C_BASE_RST;
      r_r.pm_base  <= bavms_pkg::PM_BASE_RST;
      r_r.ctrl     <= bavms_pkg::CTRL_RST;
      r_r.boot     <= bavms_pkg::BOOT_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign I2C_ACK   = r_r.i2c_ack;
  assign PM_ACK    = r_r.pm_ack;
  assign ADC_START = r_r.adc_start;
  assign CFG_RDATA = r_r.rdata;
  assign VID_BAD   = r_r.vid_bad;
  assign REG_EN    = r_r.reg_en;
  assign TARGET_MV = r_r.target;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  sequence adc_handshake_s;
    (r_r.st == bavms_pkg::BAVMS_ADC_WAIT) && ADC_DONE;
  endsequence

  sequence vid_zero_s;
    (r_r.st == bavms_pkg::BAVMS_VID_RUN) && r_r.ctrl[bavms_pkg::CTRL_VID] &&
    VID_CMD.valid && (VID_CMD.code == 8'h00);
  endsequence

  rst_defaults_a: assert property (disable iff (1'b0) SRST |=>
    (r_r.i2c_base == 7'h10) && (r_r.pm_base == 7'h40)) else $error("bad base defaults");
  i2c_zero_a: assert property (I2C_ACK |-> $past(r_r.i2c_base) != 7'h00)
    else $error("i2c answered with zero base");
  pm_zero_a: assert property (PM_ACK |-> $past(r_r.pm_base) != 7'h00)
    else $error("pmbus answered with zero base");
  i2c_match_a: assert property (init_done && I2C_REQ.valid && (r_r.i2c_base != 7'h00) &&
    (I2C_REQ.addr == 7'(r_r.i2c_base + ofs_use)) |=> I2C_ACK) else $error("i2c match missed");
  pm_match_a: assert property (init_done && PM_REQ.valid && (r_r.pm_base != 7'h00) &&
    (PM_REQ.addr == 7'(r_r.pm_base + ofs_use)) |=> PM_ACK) else $error("pmbus match missed");
  ign_ofs_a: assert property (I2C_ACK && $past(r_r.ctrl[0]) |->
    $past(I2C_REQ.addr) == $past(r_r.i2c_base)) else $error("offset not ignored");
  adc_once_a: assert property (adc_handshake_s |=>
    (r_r.st == bavms_pkg::BAVMS_RUN_PM) && (r_r.ofs == $past(band)) ##0 !ADC_START [*3])
    else $error("strap sample not taken once");
  adc_pulse_a: assert property (ADC_START |=> !ADC_START)
    else $error("strap request longer than one cycle");
  ofs_hold_a: assert property (init_done && $past(init_done) |-> $stable(r_r.ofs))
    else $error("strap offset changed after init");
  band_low_a: assert property ((res_ohm < bavms_pkg::BAND_EDGE[0]) |-> (band == 4'h0))
    else $error("lowest band not offset zero");
  band_high_a: assert property ((res_ohm >= bavms_pkg::BAND_EDGE[bavms_pkg::EDGE_N-1]) |->
    (band == 4'hF)) else $error("highest band not offset fifteen");
  i2c_base_wr_a: assert property (CFG_WE && (CFG_SEL == bavms_pkg::SEL_I2C) |=>
    ({1'b0, r_r.i2c_base} == ($past(CFG_WDATA) & 8'h7F))) else $error("i2c base write lost");
  pm_base_wr_a: assert property (CFG_WE && (CFG_SEL == bavms_pkg::SEL_PM) |=>
    ({1'b0, r_r.pm_base} == ($past(CFG_WDATA) & 8'h7F))) else $error("pmbus base write lost");
  ign_ofs_pm_a: assert property (PM_ACK && $past(r_r.ctrl[0]) |->
    $past(PM_REQ.addr) == $past(r_r.pm_base)) else $error("pmbus offset not ignored");
  boot_load_a: assert property ((r_r.st == bavms_pkg::BAVMS_RUN_PM) && r_r.ctrl[1] |=>
    (r_r.st == bavms_pkg::BAVMS_VID_BOOT) && (r_r.tgt == $past(r_r.boot)))
    else $error("boot code not loaded");
  vid_follow_a: assert property ((r_r.st == bavms_pkg::BAVMS_VID_RUN) && r_r.ctrl[1] &&
    VID_CMD.valid && (VID_CMD.code >= 8'h1F) |=> ({1'b1, r_r.tgt} == $past(VID_CMD)))
    else $error("cpu code not followed");
  vid_zero_tgt_a: assert property (vid_zero_s |=> (r_r.cur == 8'h00) && (r_r.tgt == 8'h00))
    else $error("zero code left a target");
  pm_reg_en_a: assert property ((r_r.st == bavms_pkg::BAVMS_RUN_PM) &&
    ($past(r_r.st) == bavms_pkg::BAVMS_RUN_PM) |-> REG_EN) else $error("pmbus mode not enabled");
  bad_in_run_a: assert property (VID_BAD |-> $past(r_r.st) == bavms_pkg::BAVMS_VID_RUN)
    else $error("invalid flag outside run state");
  no_early_ack_a: assert property (!init_done |=> !I2C_ACK && !PM_ACK)
    else $error("ack before init");
  vid_zero_a: assert property (vid_zero_s |=> !REG_EN ##1 (TARGET_MV == 12'h000))
    else $error("zero code did not shut down");
  pm_mode_a: assert property ((r_r.st == bavms_pkg::BAVMS_RUN_PM) &&
    ($past(r_r.st) == bavms_pkg::BAVMS_RUN_PM) |-> TARGET_MV == $past(r_r.pm_vout))
    else $error("pmbus target not followed");
  vid_table_a: assert property ((r_r.st == bavms_pkg::BAVMS_VID_RUN) &&
    (r_r.cur == 8'hFF) |=> TARGET_MV == 12'h5F0) else $error("code FF not 1.52 V");
  vid_bad_a: assert property ((r_r.st == bavms_pkg::BAVMS_VID_RUN) && r_r.ctrl[1] &&
    VID_CMD.valid && (VID_CMD.code != 8'h00) && (VID_CMD.code < 8'h1F) |=> VID_BAD)
    else $error("invalid code not flagged");
  // one code step per ramp period while the boot target is not reached
  boot_ramp_a: assert property ((r_r.st == bavms_pkg::BAVMS_VID_BOOT) && r_r.ctrl[1] &&
    (r_r.tgt != 8'h00) && (r_r.cur != r_r.tgt) |->
    (r_r.tgt == r_r.boot) ##[1:RAMP_CYCLES] (r_r.cur != $past(r_r.cur)))
    else $error("boot ramp stalled");
endmodule

// *** dv/bavms_strap_adc.sv ***
// strap resistor converter model answering start requests
// assumes strap code and answer lag are set by the bench
`timescale 1ns/1ps
module bavms_strap_adc (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [3:0] lag,
  input  wire logic [9:0] code,
  output logic            done,
  output logic [9:0]      data
);
  logic [3:0] cnt_r = 4'h0;
  initial begin
    done = 1'b0;
    data = 10'h155;
  end
  // data toggles outside the result cycle so a late sample is never trusted
  always @(posedge clk) begin
    if (start) begin
      cnt_r <= lag;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
    done <= (cnt_r == 4'h1);
    data <= (cnt_r == 4'h1) ? code : ~data;
  end
endmodule

// *** dv/bus_address_and_vid_mode_select_tb.sv ***
// self-checking bench for address matching and setpoint source selection
// assumes the strap converter model and a 100 ns clock
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module bus_address_and_vid_mode_select_tb;
  typedef struct {int due; int sel; logic [11:0] exp; string name;} bavms_note_t;
  logic                       CLOCK = 1'b0;
  logic                       SRST = 1'b1;
  bavms_pkg::bavms_addr_req_t i2c_req = '0, pm_req = '0;
  bavms_pkg::bavms_vid_cmd_t  vid_cmd = '0;
  logic       i2c_ack, pm_ack, adc_start, adc_done, vid_bad, reg_en;
  logic       cfg_we = 1'b0, pm_vout_we = 1'b0;
  logic [2:0] cfg_sel = 3'h0;
  logic [7:0] cfg_wdata = 8'h00, cfg_rdata, c;
  logic [9:0] adc_data, strap_code = 10'h000;
  logic [3:0] lag = 4'h1;
  logic [11:0] pm_vout = 12'h000, target_mv;
  logic [31:0] seed = 32'h0000005A;
  int          cyc = 0, mismatches = 0, samples_checked = 0;
  bavms_note_t pend[$];
  logic [9:0]  codes [4] = '{10'h040, 10'h041, 10'h37C, 10'h3E8};
  logic [6:0]  ofs [4]   = '{7'h00, 7'h01, 7'h0E, 7'h0F};

  always #50 CLOCK = ~CLOCK;
  bavms_top #(.RAMP_CYCLES(2)) u_dut (.CLOCK(CLOCK), .SRST(SRST), .I2C_REQ(i2c_req),
    .PM_REQ(pm_req), .I2C_ACK(i2c_ack), .PM_ACK(pm_ack), .ADC_START(adc_start),
    .ADC_DONE(adc_done), .ADC_DATA(adc_data), .CFG_WE(cfg_we), .CFG_SEL(cfg_sel),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .PM_VOUT_WE(pm_vout_we), .PM_VOUT(pm_vout),
    .VID_CMD(vid_cmd), .VID_BAD(vid_bad), .REG_EN(reg_en), .TARGET_MV(target_mv));
  bavms_strap_adc u_adc (.clk(CLOCK), .start(adc_start), .lag(lag), .code(strap_code),
    .done(adc_done), .data(adc_data));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] pick(int sel);
    case (sel)
      0: return {11'h000, i2c_ack};
      1: return {11'h000, pm_ack};
      2: return {4'h0, cfg_rdata};
      3: return target_mv;
      4: return {11'h000, reg_en};
      5: return {11'h000, vid_bad};
      default: return {11'h000, adc_start};
    endcase
  endfunction
  function automatic logic [11:0] mv(logic [7:0] code);
    return 12'(400 + (int'(code) - 31) * 5);
  endfunction
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
  end
  // every due note is compared mid-cycle, oldest first, once registered outputs have settled
  always @(negedge CLOCK) begin
    while (pend.size() > 0 && pend[0].due <= cyc) begin
      `CHK(pend[0].name, pend[0].exp, pick(pend[0].sel))
      void'(pend.pop_front());
    end
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic note(int sel, logic [11:0] exp, string name, int lat = 1);
    pend.push_back('{cyc + lat, sel, exp, name});
  endtask
  task automatic wr(logic [2:0] sel, logic [7:0] d);
    cfg_we = 1'b1;
    cfg_sel = sel;
    cfg_wdata = d;
    tick();
    cfg_we = 1'b0;
    tick();
  endtask
  task automatic rd(logic [2:0] sel, logic [7:0] exp);
    cfg_sel = sel;
    note(2, {4'h0, exp}, "cfg_rdata");
    tick();
  endtask
  task automatic req(bit pm, logic [6:0] a, bit hit);
    if (pm) pm_req = '{1'b1, a};
    else i2c_req = '{1'b1, a};
    note(pm ? 1 : 0, {11'h000, hit}, "ack");
    tick();
    pm_req.valid = 1'b0;
    i2c_req.valid = 1'b0;
    tick();
  endtask
  task automatic vid(logic [7:0] code);
    vid_cmd = '{1'b1, code};
    tick();
    vid_cmd.valid = 1'b0;
    tick();
  endtask
  task automatic wait_code(logic [7:0] code);
    cfg_sel = 3'h5;
    for (int i = 0; i < 1000 && cfg_rdata !== code; i++) tick();
    tick();
    note(3, mv(code), "target_mv");
    rd(3'h5, code);
  endtask
  task automatic wrap_up();
    $display("samples_checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    mismatches++;
    wrap_up();
  end
  initial begin
    foreach (codes[k]) begin
      strap_code = codes[k];
      lag = 4'(1 + rnd() % 3);
      SRST = 1'b1;
      tick(2);
      SRST = 1'b0;
      note(6, 12'h001, "adc_start");
      req(0, 7'h10, 1'b0);
      tick(8);
      note(6, 12'h000, "adc_start");
      rd(3'h0, 8'h10);
      rd(3'h1, 8'h40);
      rd(3'h4, 8'h10 | {1'b0, ofs[k]});
      req(0, 7'h10 + ofs[k], 1'b1);
      req(1, 7'h40 + ofs[k], 1'b1);
      req(0, 7'h11 + ofs[k], 1'b0);
      $display("test strap %0d done", k);
    end
    wr(3'h2, 8'h01);
    req(0, 7'h10, 1'b1);
    req(1, 7'h4F, 1'b0);
    wr(3'h2, 8'hFC);
    rd(3'h2, 8'h00);
    wr(3'h4, 8'hAA);
    rd(3'h4, 8'h1F);
    wr(3'h0, 8'h00);
    req(0, 7'h0F, 1'b0);
    req(1, 7'h4F, 1'b1);
    wr(3'h0, 8'h7F);
    wr(3'h1, 8'h00);
    req(1, 7'h0F, 1'b0);
    req(0, 7'h0E, 1'b1);
    $display("test enables done");
    pm_vout = 12'h4B0;
    pm_vout_we = 1'b1;
    note(3, 12'h4B0, "target_mv", 2);
    note(4, 12'h001, "reg_en", 2);
    tick();
    pm_vout_we = 1'b0;
    tick(2);
    $display("test pmbus setpoint done");
    wr(3'h1, 8'h40);
    wr(3'h3, 8'h21);
    wr(3'h2, 8'h02);
    wait_code(8'h21);
    req(1, 7'h4F, 1'b1);
    for (int j = 0; j < 4; j++) begin
      c = (j == 0) ? 8'hFF : 8'h1F + 8'(rnd() % 225);
      vid(c);
      wait_code(c);
    end
    note(5, 12'h001, "vid_bad");
    vid(8'h1E);
    tick();
    note(5, 12'h001, "vid_bad");
    vid(8'h01);
    rd(3'h5, c);
    note(4, 12'h000, "reg_en", 2);
    note(3, 12'h000, "target_mv", 2);
    vid(8'h00);
    tick(3);
    wr(3'h2, 8'h00);
    note(3, 12'h4B0, "target_mv", 2);
    note(4, 12'h001, "reg_en", 2);
    tick(3);
    $display("test vid mode done");
    wrap_up();
  end
endmodule
